// ===== hw/ptimer_pkg.sv
// Purpose: Shared constants for the four-channel timer event/clock block
// Assumes: Avalon-MM word slots, one 8-bit register per aligned word
// Notes:   Register index times four gives the byte address
package ptimer_pkg;
  // Bus geometry
  localparam int          ADDR_W       = 18;
  localparam int          DATA_W       = 32;
  localparam int          TIMERS       = 4;
  localparam int          CNT_W        = 8;
  localparam int          PRESCALE_W   = 3;
  // Register indices (byte address = index * 4)
  localparam logic [15:0] IDX_MODE     = 16'hFFC0;
  localparam logic [15:0] IDX_EVENT    = 16'hFFC1;
  localparam logic [15:0] IDX_CLKOUT   = 16'hFFC2;
  localparam logic [15:0] IDX_TCTL0    = 16'hFFC4;
  localparam logic [15:0] IDX_RELOAD0  = 16'hFFE0;
  localparam logic [15:0] IDX_COUNT0   = 16'hFFE4;
  localparam logic [15:0] IDX_FLAG     = 16'hFFF0;
  localparam logic [15:0] IDX_MASK     = 16'hFFF1;
  localparam logic [15:0] IDX_PRESCALE = 16'hFFF2;
  // Field positions
  localparam int          MODE_LO_BIT  = 0;
  localparam int          MODE_HI_BIT  = 1;
  localparam int          EV_POL_BIT   = 0;
  localparam int          EV_NR_BIT    = 1;
  localparam int          EV_SEL_BIT   = 2;
  localparam int          CO_SEL_LSB   = 0;
  localparam int          CO_EN_BIT    = 2;
  localparam int          TC_RUN_BIT   = 0;
  localparam int          TC_RST_BIT   = 1;
  localparam int          TC_PS_LSB    = 2;
  // Count clock divider selections and masks
  localparam logic [1:0]  PS_DIV1      = 2'h0;
  localparam logic [1:0]  PS_DIV4      = 2'h1;
  localparam logic [1:0]  PS_DIV32     = 2'h2;
  localparam logic [7:0]  MASK_DIV4    = 8'h03;
  localparam logic [7:0]  MASK_DIV32   = 8'h1F;
  localparam logic [7:0]  MASK_DIV256  = 8'hFF;
  // Reset values
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [31:0] RD_ZERO      = 32'h0000_0000;
endpackage

// ===== hw/ptimer_event_clkout.sv
// Purpose: Four 8-bit down timers with underflow flags, event counting
//          on timer 0 and a divide-by-two clock output
// Assumes: ref_clk is the oscillator clock; prescale stage is internal
// Notes:   Rules carried by this file follow
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module ptimer_event_clkout
  import ptimer_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              external_count_input,
  output logic                   output_port_pin,
  output logic                   irq_request
);

  // Whole-index compare, used by every single-slot register
  function automatic logic reg_hit(input logic [15:0] idx, input logic [15:0] base);
    return idx == base;
  endfunction

  // Four-slot group compare for per-timer registers
  function automatic logic group_hit(input logic [15:0] idx, input logic [15:0] base);
    return idx[15:2] == base[15:2];
  endfunction

  // Divided count-clock tick from the free-running stage
  function automatic logic div_tick(input logic [1:0] sel, input logic [7:0] cnt);
    logic t;
    t = ((cnt & MASK_DIV256) == MASK_DIV256);
    if (sel == PS_DIV1) t = 1'b1;
    else if (sel == PS_DIV4) t = ((cnt & MASK_DIV4) == MASK_DIV4);
    else if (sel == PS_DIV32) t = ((cnt & MASK_DIV32) == MASK_DIV32);
    return t;
  endfunction

  // Control and status storage
  logic [1:0]            pair_width_reg;          // Bit 0 pairs 0/1, bit 1 pairs 2/3
  logic                  event_count_select_reg;  // Timer 0 counts pin
  logic                  noise_filter_enable_reg; // Rejector in path
  logic                  edge_polarity_reg;       // 1 rising, 0 falling
  logic [1:0]            output_channel_reg;      // Clock output source
  logic                  clkout_enable_reg;       // Clock output on pin
  logic [PRESCALE_W-1:0] prescaler_setting_reg;   // n minus one
  logic [TIMERS-1:0]     run_reg;                 // Per-timer run
  logic [1:0]            div_sel_reg [TIMERS];    // Per-timer divider select
  logic [CNT_W-1:0]      reload_value_reg [TIMERS];
  logic [CNT_W-1:0]      count_reg [TIMERS];
  logic [TIMERS-1:0]     underflow_flag_reg;      // Sticky underflow flags
  logic [TIMERS-1:0]     irq_mask_reg;            // Request masks
  logic                  timer_clock_output_reg;  // Half-rate toggle
  logic [7:0]            base_div_reg;            // Free-running divider
  logic [PRESCALE_W-1:0] noise_div_reg;           // Counts /256 ticks up to the setting, n minus one
  logic                  cin_meta_reg;            // Synchroniser first stage
  logic                  cin_sync_reg;            // Synchroniser second stage
  logic                  nr_level_reg;            // Level seen by counter
  logic                  nr_pending_reg;          // One noise tick seen since change
  logic                  prev_level_reg;          // For edge detection

  // Bus decode
  wire logic [15:0] idx      = avs_address[ADDR_W-1:2];
  wire logic [1:0]  slot     = idx[1:0];
  wire logic        take     = !avs_waitrequest;
  wire logic        wr       = avs_write && take && avs_byteenable[0];
  wire logic [7:0]  wbyte    = avs_writedata[7:0];
  wire logic        wr_mode  = wr && reg_hit(idx, IDX_MODE);
  wire logic        wr_event = wr && reg_hit(idx, IDX_EVENT);
  wire logic        wr_clko  = wr && reg_hit(idx, IDX_CLKOUT);
  wire logic        wr_flag  = wr && reg_hit(idx, IDX_FLAG);
  wire logic        wr_mask  = wr && reg_hit(idx, IDX_MASK);
  wire logic        wr_pres  = wr && reg_hit(idx, IDX_PRESCALE);
  wire logic        wr_tctl  = wr && group_hit(idx, IDX_TCTL0);
  wire logic        wr_rld   = wr && group_hit(idx, IDX_RELOAD0);

  // Prescale and noise clock
  wire logic tick_256   = (base_div_reg == MASK_DIV256);
  wire logic noise_tick = tick_256 && (noise_div_reg == prescaler_setting_reg);

  // Counted level and selected edge
  wire logic event_pulse = edge_polarity_reg ? (nr_level_reg && !prev_level_reg)
                                             : (!nr_level_reg && prev_level_reg);

  // Per-timer strobes
  logic [TIMERS-1:0] preset_own;   // Software preset written to this slot
  logic [TIMERS-1:0] preset_eff;   // Preset that acts on this counter
  logic [TIMERS-1:0] run_eff;      // Run that acts on this counter
  logic [TIMERS-1:0] count_tick;   // Count clock enable
  logic [TIMERS-1:0] underflow;    // One-cycle underflow pulse
  logic [TIMERS-1:0] flag_set;     // Underflows that may flag

  genvar i;
  generate
    for (i = 0; i < TIMERS; i++) begin : g_timer
      localparam int PAIR = i / 2;
      assign preset_own[i] = wr_tctl && (slot == 2'(i)) && wbyte[TC_RST_BIT];
      if (i % 2 == 1) begin : g_high
        // High side follows the low side's run and preset when chained
        assign run_eff[i]    = pair_width_reg[PAIR] ? run_reg[i-1] : run_reg[i];
        assign preset_eff[i] = pair_width_reg[PAIR] ? preset_own[i-1] : preset_own[i];
        assign count_tick[i] = pair_width_reg[PAIR] ? underflow[i-1]
                                                    : div_tick(div_sel_reg[i], base_div_reg);
        assign flag_set[i]   = underflow[i];
      end else begin : g_low
        assign run_eff[i]    = run_reg[i];
        assign preset_eff[i] = preset_own[i];
        if (i == 0) begin : g_evt
          // Event mode takes the pin edge and drops the divider choice
          assign count_tick[i] = event_count_select_reg ? event_pulse
                                                        : div_tick(div_sel_reg[i], base_div_reg);
        end else begin : g_div
          assign count_tick[i] = div_tick(div_sel_reg[i], base_div_reg);
        end
        assign flag_set[i] = underflow[i] && !pair_width_reg[PAIR];
      end
      assign underflow[i] = run_eff[i] && count_tick[i] && (count_reg[i] == RST_BYTE);

      // Control slot: divider select and run
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          div_sel_reg[i] <= PS_DIV1;
          run_reg[i]     <= 1'b0;
        end else if (wr_tctl && slot == 2'(i)) begin
          div_sel_reg[i] <= wbyte[TC_PS_LSB +: 2];
          run_reg[i]     <= wbyte[TC_RUN_BIT];
        end
      end

      // Reload value
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          reload_value_reg[i] <= RST_BYTE;
        end else if (wr_rld && slot == 2'(i)) begin
          reload_value_reg[i] <= wbyte;
        end
      end

      // Down counter; same path whatever feeds its tick
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          count_reg[i] <= RST_BYTE;
        end else if (preset_eff[i]) begin
          count_reg[i] <= reload_value_reg[i];
        end else if (underflow[i]) begin
          count_reg[i] <= reload_value_reg[i];
        end else if (run_eff[i] && count_tick[i]) begin
          count_reg[i] <= count_reg[i] - 8'h01;
        end
      end
    end
  endgenerate

  // Mode, event and clock-output controls
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pair_width_reg          <= 2'h0;
      event_count_select_reg  <= 1'b0;
      noise_filter_enable_reg <= 1'b0;
      edge_polarity_reg       <= 1'b0;
      output_channel_reg      <= 2'h0;
      clkout_enable_reg       <= 1'b0;
      prescaler_setting_reg   <= '0;
      irq_mask_reg            <= '0;
    end else begin
      if (wr_mode) begin
        pair_width_reg <= {wbyte[MODE_HI_BIT], wbyte[MODE_LO_BIT]};
      end
      if (wr_event) begin
        event_count_select_reg  <= wbyte[EV_SEL_BIT];
        noise_filter_enable_reg <= wbyte[EV_NR_BIT];
        edge_polarity_reg       <= wbyte[EV_POL_BIT];
      end
      if (wr_clko) begin
        output_channel_reg <= wbyte[CO_SEL_LSB +: 2];
        clkout_enable_reg  <= wbyte[CO_EN_BIT];
      end
      if (wr_pres) begin
        prescaler_setting_reg <= wbyte[PRESCALE_W-1:0];
      end
      if (wr_mask) begin
        irq_mask_reg <= wbyte[TIMERS-1:0];
      end
    end
  end

  // Sticky flags: an underflow in the clearing cycle still sets
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      underflow_flag_reg <= '0;
    end else begin
      underflow_flag_reg <= (underflow_flag_reg & ~(wr_flag ? wbyte[TIMERS-1:0] : '0))
                            | flag_set;
    end
  end

  // Request is the OR of unmasked flags, registered
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= |(underflow_flag_reg & irq_mask_reg);
    end
  end

  // Free-running divider and noise clock stage
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      base_div_reg  <= RST_BYTE;
      noise_div_reg <= '0;
    end else begin
      base_div_reg <= base_div_reg + 8'h01;
      if (noise_tick) begin
        noise_div_reg <= '0;
      end else if (tick_256) begin
        noise_div_reg <= noise_div_reg + PRESCALE_W'(1);
      end
    end
  end

  // Pin synchroniser; only the second stage is read
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cin_meta_reg <= 1'b0;
      cin_sync_reg <= 1'b0;
    end else begin
      cin_meta_reg <= external_count_input;
      cin_sync_reg <= cin_meta_reg;
    end
  end

  // Noise rejector: a change must survive two noise ticks, so a pulse
  // of one noise period or less never reaches the counter
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      nr_level_reg   <= 1'b0;
      nr_pending_reg <= 1'b0;
      prev_level_reg <= 1'b0;
    end else begin
      prev_level_reg <= nr_level_reg;
      if (!noise_filter_enable_reg) begin
        nr_level_reg   <= cin_sync_reg;
        nr_pending_reg <= 1'b0;
      end else if (cin_sync_reg == nr_level_reg) begin
        nr_pending_reg <= 1'b0;
      end else if (noise_tick) begin
        nr_pending_reg <= !nr_pending_reg;
        if (nr_pending_reg) begin
          nr_level_reg <= cin_sync_reg;
        end
      end
    end
  end

  // Clock output: toggle on the chosen underflow, pin high when off.
  // Enable is not aligned to the waveform, so a short half-cycle may show.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      timer_clock_output_reg <= 1'b0;
      output_port_pin        <= 1'b1;
    end else begin
      if (underflow[output_channel_reg]) begin
        timer_clock_output_reg <= !timer_clock_output_reg;
      end
      output_port_pin <= clkout_enable_reg ? timer_clock_output_reg : 1'b1;
    end
  end

  // Read data selection; unmapped slots read zero
  wire logic [7:0] tctl_rd = {4'h0, div_sel_reg[slot], 1'b0, run_reg[slot]};
  wire logic [7:0] rd_byte =
    reg_hit(idx, IDX_MODE)     ? {6'h00, pair_width_reg} :
    reg_hit(idx, IDX_EVENT)    ? {5'h00, event_count_select_reg, noise_filter_enable_reg,
                                  edge_polarity_reg} :
    reg_hit(idx, IDX_CLKOUT)   ? {5'h00, clkout_enable_reg, output_channel_reg} :
    reg_hit(idx, IDX_FLAG)     ? {4'h0, underflow_flag_reg} :
    reg_hit(idx, IDX_MASK)     ? {4'h0, irq_mask_reg} :
    reg_hit(idx, IDX_PRESCALE) ? {5'h00, prescaler_setting_reg} :
    group_hit(idx, IDX_TCTL0)  ? tctl_rd :
    group_hit(idx, IDX_RELOAD0) ? reload_value_reg[slot] :
    group_hit(idx, IDX_COUNT0) ? count_reg[slot] : RST_BYTE;

  // Slave handshake: one wait cycle, then a one-cycle low waitrequest
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= RD_ZERO;
    end else if (avs_waitrequest && (avs_read || avs_write)) begin
      avs_waitrequest <= 1'b0;
      if (avs_read) begin
        avs_readdata <= {24'h00_0000, rd_byte};
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

endmodule

// ===== tb/ptimer_checker_asserts.sv
// Purpose: Port checks for the timer event/clock block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to the top module after the module
`timescale 1ns/1ps
module ptimer_checker
  import ptimer_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              reset_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              external_count_input,
  input wire logic              output_port_pin,
  input wire logic              irq_request
);
  wire  [15:0] idx;         // Register index of the request
  wire         mapped;      // Index hits a register
  wire         taken_rd;    // Read seen by the slave
  wire         commit;      // Write takes effect here
  logic        en_reg;      // Shadow of the output enable
  logic [1:0]  off_cnt_reg; // Cycles since output disabled
  assign idx = avs_address[17:2];
  assign mapped = (idx >= IDX_MODE && idx <= IDX_CLKOUT)
    || (idx >= IDX_TCTL0 && idx <= IDX_TCTL0 + 16'h0003)
    || (idx >= IDX_RELOAD0 && idx <= IDX_RELOAD0 + 16'h0007)
    || (idx >= IDX_FLAG && idx <= IDX_PRESCALE);
  assign taken_rd = avs_read && avs_waitrequest;
  assign commit = avs_write && !avs_waitrequest && avs_byteenable[0];
  // Saturating count lets the pin settle after disable
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      en_reg <= 1'b0;
      off_cnt_reg <= 2'h0;
    end else begin
      if (commit && idx == IDX_CLKOUT) begin
        en_reg <= avs_writedata[CO_EN_BIT];
      end
      off_cnt_reg <= en_reg ? 2'h0 : (off_cnt_reg == 2'h3 ? 2'h3 : off_cnt_reg + 2'h1);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_wait_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("request not answered");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  property p_wait_idle;
    !avs_read && !avs_write |=> avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
  property p_rd_upper;
    !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  property p_unmapped;
    taken_rd && !mapped |=> avs_readdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_preset_rd;
    taken_rd && idx >= IDX_TCTL0 && idx <= IDX_TCTL0 + 16'h0003 |=> !avs_readdata[TC_RST_BIT];
  endproperty
  a_preset_rd: assert property (p_preset_rd) else $error("preset bit reads one");
  property p_reset_out;
    $rose(reset_n) |-> output_port_pin && !irq_request;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not idle");
  property p_mask_off;
    commit && idx == IDX_MASK && avs_writedata[3:0] == 4'h0 |-> ##2 !irq_request;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("masked request raised");
  property p_pin_idle;
    off_cnt_reg == 2'h3 |-> output_port_pin;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("disabled pin not high");
  c_irq: cover property ($rose(irq_request));
  c_pin: cover property ($changed(output_port_pin));
  c_unmapped: cover property (taken_rd && !mapped);
endmodule
bind ptimer_event_clkout ptimer_checker ptimer_checker_i (.ref_clk, .reset_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .external_count_input, .output_port_pin, .irq_request);

// ===== tb/ptimer_far_side.sv
// Purpose: External pulse source and clock consumer
// Assumes: Pin driven at rising edges of ref_clk
// Notes:   Consumer logs the spacing of output changes
`timescale 1ns/1ps
module ptimer_far_side (
  input  wire logic ref_clk,
  output logic      external_count_input,
  input  wire logic output_port_pin
);
  logic pin_q     = 1'b1; // Last seen output level
  int   gap_cnt   = 0;    // Cycles since last change
  int   last_gap  = 0;    // Spacing of the last two changes
  int   n_toggle  = 0;    // Changes seen so far
  initial external_count_input = 1'b0;
  // Toggle the pin n times, each level held for hold cycles
  task automatic make_edges(input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      external_count_input <= ~external_count_input;
      repeat (hold - 1) @(posedge ref_clk);
    end
  endtask
  // Pin is actively driven, so every change is a real edge
  always @(posedge ref_clk) begin
    pin_q <= output_port_pin;
    if (output_port_pin !== pin_q) begin
      last_gap <= gap_cnt;
      gap_cnt <= 1;
      n_toggle <= n_toggle + 1;
    end else begin
      gap_cnt <= gap_cnt + 1;
    end
  end
endmodule

// ===== tb/ptimer_event_clkout_tb.sv
// Purpose: Self-checking bench for the timer event/clock block
// Assumes: 100 MHz ref_clk, Avalon-MM master with waitrequest
// Notes:   Each scenario drives and judges before returning
`timescale 1ns/1ps
module ptimer_event_clkout_tb
  import ptimer_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              reset_n;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read, avs_write, avs_waitrequest;
  logic [DATA_W-1:0] avs_writedata, avs_readdata;
  logic [3:0]        avs_byteenable;
  logic              external_count_input, output_port_pin, irq_request;
  logic [7:0]        rd;           // Last read byte
  int                n_mismatch = 0;
  int                total_checks = 0;
  always #5 ref_clk = ~ref_clk;
  ptimer_event_clkout ptimer_event_clkout_i (.ref_clk, .reset_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .external_count_input, .output_port_pin, .irq_request);
  ptimer_far_side ptimer_far_side_i (.ref_clk, .external_count_input, .output_port_pin);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] d,
                     input logic [3:0] be);
    @(posedge ref_clk);
    avs_address <= {idx, 2'h0};
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hF);
  endtask
  task automatic rdv(input logic [15:0] idx);
    bus(1'b0, idx, 8'h00, 4'hF);
  endtask
  task automatic t_reset;
    logic [15:0] list [6] = '{IDX_MODE, IDX_EVENT, IDX_CLKOUT, IDX_FLAG, IDX_MASK, 16'h0000};
    foreach (list[i]) begin
      rdv(list[i]);
      chk(rd, 8'h00);
    end
    chk(output_port_pin, 1'b1);
    chk(irq_request, 1'b0);
    bus(1'b1, IDX_MASK, 8'h0F, 4'hE);
    rdv(IDX_MASK);
    chk(rd, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_irq;
    wr(IDX_RELOAD0 + 16'h0003, 8'h03);
    wr(IDX_TCTL0 + 16'h0003, 8'h03);
    repeat (20) @(posedge ref_clk);
    rdv(IDX_FLAG);
    chk(rd[3], 1'b1);
    chk(irq_request, 1'b0);
    wr(IDX_MASK, 8'h08);
    repeat (3) @(posedge ref_clk);
    chk(irq_request, 1'b1);
    wr(IDX_MASK, 8'h00);
    repeat (3) @(posedge ref_clk);
    chk(irq_request, 1'b0);
    $display("test irq done");
  endtask
  task automatic t_clkout;
    int n;
    wr(IDX_CLKOUT, 8'h07);
    repeat (40) @(posedge ref_clk);
    chk(ptimer_far_side_i.last_gap, 4);
    wr(IDX_CLKOUT, 8'h03);
    repeat (5) @(posedge ref_clk);
    n = ptimer_far_side_i.n_toggle;
    repeat (20) @(posedge ref_clk);
    chk(ptimer_far_side_i.n_toggle, n);
    chk(output_port_pin, 1'b1);
    wr(IDX_TCTL0 + 16'h0003, 8'h00);
    wr(IDX_FLAG, 8'h0F);
    rdv(IDX_FLAG);
    chk(rd, 8'h00);
    $display("test clkout done");
  endtask
  // Divider at /1 would drain the count fast if not ignored
  task automatic t_event;
    wr(IDX_EVENT, 8'h05);
    wr(IDX_RELOAD0, 8'h10);
    wr(IDX_TCTL0, 8'h03);
    rdv(IDX_TCTL0);
    chk(rd, 8'h01);
    ptimer_far_side_i.make_edges(4, 10);
    repeat (10) @(posedge ref_clk);
    rdv(IDX_COUNT0);
    chk(rd, 8'h0E);
    wr(IDX_EVENT, 8'h04);
    wr(IDX_TCTL0, 8'h03);
    ptimer_far_side_i.make_edges(3, 10);
    repeat (10) @(posedge ref_clk);
    rdv(IDX_COUNT0);
    chk(rd, 8'h0F);
    $display("test event done");
  endtask
  // Short glitch is dropped, long pulse counted once
  task automatic t_filter;
    wr(IDX_EVENT, 8'h07);
    repeat (600) @(posedge ref_clk);
    wr(IDX_TCTL0, 8'h03);
    ptimer_far_side_i.make_edges(2, 100);
    ptimer_far_side_i.make_edges(2, 600);
    rdv(IDX_COUNT0);
    chk(rd, 8'h0F);
    // Setting one doubles the noise period to 512 cycles
    wr(IDX_PRESCALE, 8'h01);
    wr(IDX_TCTL0, 8'h03);
    ptimer_far_side_i.make_edges(2, 400);
    ptimer_far_side_i.make_edges(2, 1100);
    rdv(IDX_COUNT0);
    chk(rd, 8'h0F);
    $display("test filter done");
  endtask
  task automatic t_chain;
    wr(IDX_TCTL0, 8'h00);
    wr(IDX_EVENT, 8'h00);
    wr(IDX_MODE, 8'h01);
    wr(IDX_RELOAD0, 8'h01);
    wr(IDX_RELOAD0 + 16'h0001, 8'h01);
    wr(IDX_FLAG, 8'h0F);
    wr(IDX_CLKOUT, 8'h05);
    wr(IDX_TCTL0, 8'h03);
    repeat (40) @(posedge ref_clk);
    chk(ptimer_far_side_i.last_gap, 4);
    wr(IDX_TCTL0, 8'h00);
    rdv(IDX_FLAG);
    chk(rd[1:0], 2'h2);
    // Chained event count: two rising edges carry into the high timer
    wr(IDX_EVENT, 8'h05);
    wr(IDX_TCTL0, 8'h03);
    ptimer_far_side_i.make_edges(4, 10);
    repeat (10) @(posedge ref_clk);
    rdv(IDX_COUNT0);
    chk(rd, 8'h01);
    rdv(IDX_COUNT0 + 16'h0001);
    chk(rd, 8'h00);
    $display("test chain done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    reset_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'h0;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset;
    t_irq;
    t_clkout;
    t_event;
    t_filter;
    t_chain;
    report_and_stop;
  end
  // Watchdog well beyond the few thousand cycles expected
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    report_and_stop;
  end
endmodule
